/* File: rtl/ccm_pkg.sv */
// Purpose : Constants for the CPU clock mode select block
// Assumes : 25 MHz system clock, AXI4-Lite register access
// Notes   : Offsets are byte addresses of 32-bit words
package ccm_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0]  ADDR_RST_CFG_LATCH = 4'h0;
   localparam logic [3:0]  ADDR_RST_CONTROL   = 4'h4;
   localparam logic [3:0]  ADDR_RELOAD        = 4'h8;
   localparam logic [3:0]  ADDR_STATUS        = 4'hC;
   localparam logic [7:0]  LATCH_RESET        = 8'hFF;
   localparam logic [15:0] CONTROL_RESET      = 16'hFF00;
   localparam int          CFG_MSB            = 7;
   localparam int          CFG_LSB            = 5;
   localparam int          CTRL_UPPER_MSB     = 15;
   localparam int          CTRL_UPPER_LSB     = 8;
   localparam int          RELOAD_BIT         = 0;
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;

   // ****************************************
   // Clock source select encodings
   // ****************************************
   typedef enum logic [2:0] {
      CCM_MUL4     = 3'h7,
      CCM_MUL3     = 3'h6,
      CCM_MUL2     = 3'h5,
      CCM_MUL5     = 3'h4,
      CCM_DIRECT   = 3'h3,
      CCM_MUL1P5   = 3'h2,
      CCM_PRESCALE = 3'h1,
      CCM_MUL2P5   = 3'h0
   } ccm_mode_type;

   // ****************************************
   // Timing
   // ****************************************
   localparam int          CLK_HZ             = 25000000;
   localparam int          CNT_W              = 16;
   localparam logic [15:0] CNT_MAX            = 16'hFFFF;

   // Resync window in oscillator transitions, and accumulator step per clock
   // Step is 2*F*window so one window yields exactly F*window CPU edges
   localparam logic [3:0]  WIN_MUL4   = 4'h4;
   localparam logic [3:0]  WIN_MUL3   = 4'h3;
   localparam logic [3:0]  WIN_MUL2   = 4'h2;
   localparam logic [3:0]  WIN_MUL5   = 4'h5;
   localparam logic [3:0]  WIN_MUL1P5 = 4'h6;
   localparam logic [3:0]  WIN_MUL2P5 = 4'hA;
   localparam logic [7:0]  STEP_MUL4   = 8'h20;
   localparam logic [7:0]  STEP_MUL3   = 8'h12;
   localparam logic [7:0]  STEP_MUL2   = 8'h08;
   localparam logic [7:0]  STEP_MUL5   = 8'h32;
   localparam logic [7:0]  STEP_MUL1P5 = 8'h12;
   localparam logic [7:0]  STEP_MUL2P5 = 8'h32;

endpackage

/* File: rtl/ccm_top.sv */
// Purpose : CPU clock generation mode select with PLL, direct and prescaler paths
// Assumes : Oscillator and port pins are asynchronous; long reset is on clk_i
// Notes   : CPU clock is modelled as a level plus an edge strobe on clk_i
`timescale 1ns/1ps

// Overview of operation
// - Clock mode comes from latch bits 7 to 5, the clock source select field.
// - Long hardware reset loads the latch from port 0 upper byte pins.
// - Software reloads the latch from the upper half of reset control.
// - Decode: 111 x4, 110 x3, 101 x2, 100 x5, 011 x1, 010 x1.5, 001 /2, 000 x2.5.
// - Both rising and falling CPU clock edges produce an action strobe.
// - The time between two CPU clock edges is measured as the half period.
// - Prescaler mode toggles the CPU clock once per oscillator period.
// - Direct drive disables the PLL and follows the oscillator level.
// - PLL mode resynchronises to the oscillator each window without abrupt change.
module ccm_top
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        osc_i,
   input  wire logic [7:0]  port0_upper_byte_i,
   input  wire logic        long_hw_reset_i,
   output logic             cpu_clk_o,
   output logic             cpu_edge_o,
   output logic             pll_en_o,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ****************************************
   // Functions
   // ****************************************
   // Resync window length in oscillator transitions
   function automatic logic [3:0] win_of(input ccm_pkg::ccm_mode_type m);
      case (m)
         ccm_pkg::CCM_MUL4   : win_of = ccm_pkg::WIN_MUL4;
         ccm_pkg::CCM_MUL3   : win_of = ccm_pkg::WIN_MUL3;
         ccm_pkg::CCM_MUL2   : win_of = ccm_pkg::WIN_MUL2;
         ccm_pkg::CCM_MUL5   : win_of = ccm_pkg::WIN_MUL5;
         ccm_pkg::CCM_MUL1P5 : win_of = ccm_pkg::WIN_MUL1P5;
         default             : win_of = ccm_pkg::WIN_MUL2P5;
      endcase
   endfunction

   // Accumulator step per clock for the multiplier
   function automatic logic [7:0] step_of(input ccm_pkg::ccm_mode_type m);
      case (m)
         ccm_pkg::CCM_MUL4   : step_of = ccm_pkg::STEP_MUL4;
         ccm_pkg::CCM_MUL3   : step_of = ccm_pkg::STEP_MUL3;
         ccm_pkg::CCM_MUL2   : step_of = ccm_pkg::STEP_MUL2;
         ccm_pkg::CCM_MUL5   : step_of = ccm_pkg::STEP_MUL5;
         ccm_pkg::CCM_MUL1P5 : step_of = ccm_pkg::STEP_MUL1P5;
         default             : step_of = ccm_pkg::STEP_MUL2P5;
      endcase
   endfunction

   // ****************************************
   // Declarations
   // ****************************************
   logic [2:0]              osc_sync_r;
   logic                    osc_lvl_r;
   logic [7:0]              p0_s1_r;
   logic [7:0]              p0_s2_r;
   logic [7:0]              p0_s3_r;
   logic [7:0]              p0_lvl_r;
   logic [7:0]              latch_r;
   logic [15:0]             control_r;
   logic                    reload_r;
   ccm_pkg::ccm_mode_type   mode;
   logic                    osc_edge;
   logic                    osc_rise;
   logic                    pll_mode;
   logic [3:0]              trans_cnt_r;
   logic [ccm_pkg::CNT_W-1:0] win_cnt_r;
   logic [ccm_pkg::CNT_W:0] thr_r;
   logic [ccm_pkg::CNT_W:0] acc_r;
   logic [ccm_pkg::CNT_W:0] acc_nxt;
   logic                    pll_edge;
   logic                    cpu_clk_nxt;
   logic [ccm_pkg::CNT_W-1:0] tcl_cnt_r;
   logic [ccm_pkg::CNT_W-1:0] tcl_meas_r;
   logic                    wr_fire;
   logic                    rd_fire;

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge clk_i)
   begin
      osc_sync_r <= {osc_sync_r[1:0], osc_i};
      p0_s1_r    <= port0_upper_byte_i;
      p0_s2_r    <= p0_s1_r;
      p0_s3_r    <= p0_s2_r;
   end

   // Agreed levels of oscillator and port pins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         osc_lvl_r <= 1'b0;
         p0_lvl_r  <= ccm_pkg::LATCH_RESET;
      end
      else
      begin
         if (osc_sync_r[1] == osc_sync_r[2])
            osc_lvl_r <= osc_sync_r[2];
         for (int i = 0; i < 8; i++)
            if (p0_s2_r[i] == p0_s3_r[i])
               p0_lvl_r[i] <= p0_s3_r[i];
      end
   end

   assign osc_edge = (osc_sync_r[1] == osc_sync_r[2]) && (osc_sync_r[2] != osc_lvl_r);
   assign osc_rise = osc_edge && osc_sync_r[2];

   // ****************************************
   // Reset configuration latch and mode
   // ****************************************
   // Latch loads only on rst_i, long reset or software reload, else holds
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         latch_r <= ccm_pkg::LATCH_RESET;
      else if (long_hw_reset_i)
         latch_r <= p0_lvl_r;
      else if (reload_r)
         latch_r <= control_r[ccm_pkg::CTRL_UPPER_MSB:ccm_pkg::CTRL_UPPER_LSB];
   end

   assign mode     = ccm_pkg::ccm_mode_type'(latch_r[ccm_pkg::CFG_MSB:ccm_pkg::CFG_LSB]);
   assign pll_mode = (mode != ccm_pkg::CCM_DIRECT) && (mode != ccm_pkg::CCM_PRESCALE);

   // ****************************************
   // PLL model
   // ****************************************
   // Count transitions and clocks per window; at window end retune and realign
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !pll_mode)
      begin
         trans_cnt_r <= 4'h0;
         win_cnt_r   <= '0;
         thr_r       <= '0;
      end
      else
      begin
         if (win_cnt_r != ccm_pkg::CNT_MAX)
            win_cnt_r <= win_cnt_r + 1'b1;
         if (osc_edge)
         begin
            if (trans_cnt_r + 4'h1 >= win_of(mode))
            begin
               trans_cnt_r <= 4'h0;
               win_cnt_r   <= '0;
               thr_r       <= {win_cnt_r, 1'b0} + 2'd2;
            end
            else
               trans_cnt_r <= trans_cnt_r + 4'h1;
         end
      end
   end

   // Phase accumulator emitting F edges per transition on average
   always_comb
   begin
      acc_nxt  = acc_r + {{(ccm_pkg::CNT_W-7){1'b0}}, step_of(mode)};
      pll_edge = 1'b0;
      if (thr_r != '0 && acc_nxt >= thr_r)
      begin
         acc_nxt  = acc_nxt - thr_r;
         pll_edge = 1'b1;
      end
   end

   // Accumulator clears at each window boundary so edges stay locked
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !pll_mode)
         acc_r <= '0;
      else if (osc_edge && (trans_cnt_r + 4'h1 >= win_of(mode)))
         acc_r <= '0;
      else
         acc_r <= acc_nxt;
   end

   // ****************************************
   // CPU clock selection
   // ****************************************
   // Mode multiplexer for the next CPU clock level
   always_comb
   begin
      case (mode)
         ccm_pkg::CCM_DIRECT   : cpu_clk_nxt = osc_lvl_r;
         ccm_pkg::CCM_PRESCALE : cpu_clk_nxt = cpu_clk_o ^ osc_rise;
         default               : cpu_clk_nxt = cpu_clk_o ^ pll_edge;
      endcase
   end

   // CPU clock level, edge strobe on both edges, PLL enable
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cpu_clk_o  <= 1'b0;
         cpu_edge_o <= 1'b0;
         pll_en_o   <= 1'b0;
      end
      else
      begin
         cpu_clk_o  <= cpu_clk_nxt;
         cpu_edge_o <= cpu_clk_nxt != cpu_clk_o;
         pll_en_o   <= pll_mode;
      end
   end

   // Half clock period measured between consecutive CPU edges
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tcl_cnt_r  <= '0;
         tcl_meas_r <= '0;
      end
      else if (cpu_clk_nxt != cpu_clk_o)
      begin
         tcl_meas_r <= tcl_cnt_r + 1'b1;
         tcl_cnt_r  <= '0;
      end
      else if (tcl_cnt_r != ccm_pkg::CNT_MAX)
         tcl_cnt_r <= tcl_cnt_r + 1'b1;
   end

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;

   // Address and data taken together, response after both handshakes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= ccm_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= wr_fire;
         s_axi_wready  <= wr_fire;
         if (wr_fire)
            s_axi_bresp <= (s_axi_awaddr == ccm_pkg::ADDR_RST_CONTROL ||
                            s_axi_awaddr == ccm_pkg::ADDR_RELOAD) ?
                           ccm_pkg::RESP_OKAY : ccm_pkg::RESP_SLVERR;
         // Valid rises only once the ready handshake edge has passed
         if (s_axi_awready)
            s_axi_bvalid <= 1'b1;
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Control register with byte strobes, reload strobe lasts one cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         control_r <= ccm_pkg::CONTROL_RESET;
         reload_r  <= 1'b0;
      end
      else
      begin
         reload_r <= wr_fire && (s_axi_awaddr == ccm_pkg::ADDR_RELOAD) &&
                     s_axi_wstrb[0] && s_axi_wdata[ccm_pkg::RELOAD_BIT];
         if (wr_fire && s_axi_awaddr == ccm_pkg::ADDR_RST_CONTROL)
         begin
            if (s_axi_wstrb[0])
               control_r[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1])
               control_r[15:8] <= s_axi_wdata[15:8];
         end
      end
   end

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   assign rd_fire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

   // Read data captured at take, valid after the address handshake
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= ccm_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= rd_fire;
         if (rd_fire)
         begin
            s_axi_rresp  <= ccm_pkg::RESP_OKAY;
            case (s_axi_araddr)
               ccm_pkg::ADDR_RST_CFG_LATCH : s_axi_rdata <= {24'h00_0000, latch_r};
               ccm_pkg::ADDR_RST_CONTROL   : s_axi_rdata <= {16'h0000, control_r};
               ccm_pkg::ADDR_RELOAD        : s_axi_rdata <= 32'h0000_0000;
               ccm_pkg::ADDR_STATUS        : s_axi_rdata <= {pll_mode, 12'h000, latch_r[7:5], tcl_meas_r};
               default :
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= ccm_pkg::RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_arready)
            s_axi_rvalid <= 1'b1;
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

/* File: test/ccm_osc_model.sv */
// Purpose : Oscillator source feeding the clock mode select block
// Assumes : Free-running source, so it never stops between cycles
// Notes   : Half period is a multiple of the 40 ns system clock
`timescale 1ns/1ps
module ccm_osc_model
#(
   parameter int HALF_NS = 400
)
(
   output logic osc_o
);
   // Square wave with a phase offset from the system clock
   initial
   begin
      osc_o = 1'b0;
      #13;
      forever #(HALF_NS) osc_o = ~osc_o;
   end
endmodule

/* File: test/ccm_top_assertions.sv */
// Purpose : Port checker for the clock mode select block
// Assumes : One clock domain, synchronous reset rst_i
// Notes   : Attached to every instance by bind
`timescale 1ns/1ps
module ccm_top_assertions
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        long_hw_reset_i,
   input wire logic        cpu_clk_o,
   input wire logic        cpu_edge_o,
   input wire logic        pll_en_o,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   logic [3:0] quiet_r;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Cycles since the last possible latch load
   always_ff @(posedge clk_i)
   begin
      if (rst_i || long_hw_reset_i || s_axi_awvalid)
         quiet_r <= 4'h0;
      else if (quiet_r != 4'hF)
         quiet_r <= quiet_r + 4'h1;
   end

   sequence s_wr_req;
      s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   endsequence
   sequence s_wr_ans;
      s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
   endsequence
   sequence s_rd_req;
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   endsequence
   sequence s_rd_ans;
      s_axi_arready ##1 s_axi_rvalid;
   endsequence

   AST_EDGE_TOGGLE: assert property (cpu_edge_o |-> cpu_clk_o != $past(cpu_clk_o))
      else $error("cpu edge strobe without clock change");
   AST_NO_EDGE_STABLE: assert property (!cpu_edge_o |-> $stable(cpu_clk_o))
      else $error("cpu clock changed without edge strobe");
   AST_MODE_QUIET: assert property (quiet_r >= 4'h4 |-> $stable(pll_en_o))
      else $error("pll enable changed without a latch load");
   AST_WR_ANSWER: assert property (s_wr_req |=> s_wr_ans)
      else $error("write ready then response not seen in order");
   AST_AW_ONE: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready held longer than one cycle");
   AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid not dropped after bready");
   AST_RD_ANSWER: assert property (s_rd_req |=> s_rd_ans)
      else $error("read ready then data not seen in order");
   AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid not dropped after rready");
endmodule

bind ccm_top ccm_top_assertions chk_u (.clk_i, .rst_i, .long_hw_reset_i, .cpu_clk_o, .cpu_edge_o, .pll_en_o,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

/* File: test/ccm_top_bench.sv */
// Purpose : Self-checking bench for the clock mode select block
// Assumes : 25 MHz clk_i, oscillator period 800 ns
// Notes   : Edge counts use a 600 cycle span, a whole number of resync windows
`timescale 1ns/1ps
module ccm_top_bench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        osc;
   logic [7:0]  p0 = 8'h00;
   logic        lhr = 1'b0;
   logic        cpu_clk, cpu_edge, pll_en;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   int          n_fail = 0;
   int          total_checks = 0;

   ccm_osc_model #(.HALF_NS(400)) osc_m (.osc_o(osc));
   ccm_top dut (.clk_i(clk_i), .rst_i(rst_i), .osc_i(osc), .port0_upper_byte_i(p0), .long_hw_reset_i(lhr),
      .cpu_clk_o(cpu_clk), .cpu_edge_o(cpu_edge), .pll_en_o(pll_en), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // System clock
   always #20 clk_i = ~clk_i;

   // **************************************
   // Shared tasks
   // **************************************
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Write with both channels offered together, held until taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
   endtask

   task automatic set_mode(input logic [2:0] m);
      logic [1:0] r;
      axi_wr(4'h4, {16'h0, m, 13'h0}, 4'h3, r);
      chk("control resp", 32'(ccm_pkg::RESP_OKAY), 32'(r));
      axi_wr(4'h8, 32'h1, 4'h1, r);
      chk("reload resp", 32'(ccm_pkg::RESP_OKAY), 32'(r));
   endtask

   // **************************************
   // Scenarios
   // **************************************
   task automatic t_reset;
      logic [31:0] d;
      axi_rd(4'h0, d);
      chk("latch reset", 32'h0000_00FF, d);
      chk("read resp", 32'(ccm_pkg::RESP_OKAY), 32'(rresp));
      axi_rd(4'h4, d);
      chk("control reset", 32'h0000_FF00, d);
      axi_rd(4'hC, d);
      chk("reset mode", 32'h7, 32'(d[18:16]));
      chk("reset pll", 32'h1, 32'(pll_en));
   endtask

   task automatic t_refuse;
      logic [1:0]  r;
      logic [31:0] d;
      axi_wr(4'h0, 32'h0, 4'hF, r);
      chk("ro write resp", 32'(ccm_pkg::RESP_SLVERR), 32'(r));
      axi_rd(4'h2, d);
      chk("unmapped data", 32'h0, d);
      chk("unmapped resp", 32'(ccm_pkg::RESP_SLVERR), 32'(rresp));
      axi_wr(4'h4, 32'h0000_2000, 4'h3, r);
      repeat (8) @(posedge clk_i);
      axi_rd(4'h0, d);
      chk("latch kept", 32'h0000_00FF, d);
      axi_rd(4'h4, d);
      chk("control kept", 32'h0000_2000, d);
   endtask

   task automatic t_long;
      logic [31:0] d;
      @(posedge clk_i);
      p0 <= 8'h7A;
      lhr <= 1'b1;
      repeat (8) @(posedge clk_i);
      lhr <= 1'b0;
      p0 <= 8'h00;
      repeat (8) @(posedge clk_i);
      axi_rd(4'h0, d);
      chk("long reset latch", 32'h0000_007A, d);
      chk("direct pll", 32'h0, 32'(pll_en));
   endtask

   // Every mode: latch, status, pll enable and edge rate over 600 cycles
   task automatic t_modes;
      int          exp_e[8] = '{150, 30, 90, 60, 300, 120, 180, 240};
      int          cnt;
      int          rise;
      logic [2:0]  mv;
      logic [31:0] d;
      for (int m = 0; m < 8; m++)
      begin
         mv = 3'(m);
         set_mode(mv);
         repeat (200) @(posedge clk_i);
         axi_rd(4'h0, d);
         chk("latch mode", {24'h0, mv, 5'h0}, d);
         chk("pll enable", 32'(mv != ccm_pkg::CCM_DIRECT && mv != ccm_pkg::CCM_PRESCALE), 32'(pll_en));
         axi_rd(4'hC, d);
         chk("status mode", 32'(mv), 32'(d[18:16]));
         chk("status pll", 32'(mv != ccm_pkg::CCM_DIRECT && mv != ccm_pkg::CCM_PRESCALE), 32'(d[31]));
         if (mv == ccm_pkg::CCM_PRESCALE || mv == ccm_pkg::CCM_DIRECT)
            chk("half period", (mv == ccm_pkg::CCM_PRESCALE) ? 32'd20 : 32'd10, 32'(d[15:0]));
         cnt = 0;
         rise = 0;
         repeat (600)
         begin
            @(negedge clk_i);
            if (cpu_edge === 1'b1) cnt++;
            if (cpu_edge === 1'b1 && cpu_clk === 1'b1) rise++;
         end
         chk("edge count", 32'(exp_e[m]), 32'(cnt));
         chk("rise count", 32'(exp_e[m] / 2), 32'(rise));
      end
   endtask

   // Watchdog
   initial
   begin
      #(40 * 40000);
      n_fail++;
      end_of_test;
   end

   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_refuse;
      t_long;
      t_modes;
      end_of_test;
   end
endmodule
